// File: rtl/spim_pkg.sv
`default_nettype none
package spim_pkg;
    localparam logic [7:0] OFS_PRESCALER   = 8'hD2;
    localparam logic [7:0] OFS_STATUS      = 8'hD3;
    localparam logic [7:0] OFS_TX_HOLD     = 8'hD4;
    localparam logic [7:0] OFS_RX_HOLD     = 8'hD5;
    localparam logic [7:0] OFS_CONTROL_A   = 8'hD6;
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'hD7;
    localparam logic [7:0] RST_PRESCALER   = 8'h04;
    localparam logic [7:0] RST_CONTROL_A   = 8'h00;
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam int POS_TX_ALLOW     = 6;
    localparam int POS_RX_ALLOW     = 5;
    localparam int POS_IF_ON        = 4;
    localparam int POS_AUTO_SEL     = 3;
    localparam int POS_LSB_FIRST    = 2;
    localparam int POS_POLARITY     = 1;
    localparam int POS_TX_DONE      = 3;
    localparam int POS_OVERRUN      = 2;
    localparam int POS_TX_EMPTY     = 1;
    localparam int POS_RX_FULL      = 0;
    localparam int POS_BUSY         = 4;
    localparam logic [7:0] PRESCALE_MASK = 8'hFC;
    localparam logic [2:0] LAST_BIT      = 3'h7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spim_sfr_req_t;

    typedef enum logic [1:0] {SPIM_IDLE, SPIM_SETUP, SPIM_LEAD, SPIM_TRAIL} spim_state_t;
endpackage
`default_nettype wire

// File: rtl/spim_master.sv
`timescale 1ns/1ps
`default_nettype none
module spim_master (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire spim_pkg::spim_sfr_req_t sfr_req,
    output logic [7:0]                   sfr_rdata,
    output logic                         spi_irq,
    output logic                         serial_clock_out,
    output logic                         serial_tx_line,
    output logic                         slave_select_out,
    input  wire logic                    serial_rx_line
);
    import spim_pkg::*;

    function automatic logic [7:0] half_period(input logic [7:0] pre);
        // Sum of weights is pre & mask; half of it gives the half period
        half_period = {1'b0, pre[7:1]} & 8'h7E;
    endfunction

    function automatic logic hit(input spim_sfr_req_t r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    logic [7:0]  serial_prescaler, next_serial_prescaler;
    logic [7:0]  serial_control_a, next_serial_control_a;
    logic [7:0]  serial_irq_control, next_serial_irq_control;
    logic [7:0]  tx_holding_reg, next_tx_holding_reg;
    logic [7:0]  rx_holding_reg, next_rx_holding_reg;
    logic        tx_empty_flag, next_tx_empty_flag;
    logic        rx_full_flag, next_rx_full_flag;
    logic        tx_done_flag, next_tx_done_flag;
    logic        overrun_flag, next_overrun_flag;
    logic [7:0]  shift_out, next_shift_out;
    logic [7:0]  shift_in, next_shift_in;
    logic [2:0]  bit_cnt, next_bit_cnt;
    logic [7:0]  div_cnt, next_div_cnt;
    spim_state_t state, next_state;
    logic        sclk, next_sclk;
    logic        txd, next_txd;
    logic        ssel, next_ssel;
    logic [7:0]  rdata, next_rdata;
    logic        irq, next_irq;

    logic tx_allow, rx_allow, serial_if_on, auto_sel, lsb_first_order, clock_idle_polarity;
    logic tick, busy;
    assign tx_allow            = serial_control_a[POS_TX_ALLOW];
    assign rx_allow            = serial_control_a[POS_RX_ALLOW];
    assign serial_if_on        = serial_control_a[POS_IF_ON];
    assign auto_sel            = serial_control_a[POS_AUTO_SEL];
    assign lsb_first_order     = serial_control_a[POS_LSB_FIRST];
    assign clock_idle_polarity = serial_control_a[POS_POLARITY];
    assign busy                = state != SPIM_IDLE;
    // A zero sum would stall; treat as the smallest divisor
    assign tick = (div_cnt == 8'h00);

    always_comb begin
        logic [7:0] st;
        logic [7:0] hp;
        logic       first_bit;
        logic       rbit;
        st = {3'h0, busy, tx_done_flag, overrun_flag, tx_empty_flag, rx_full_flag};
        hp = half_period(serial_prescaler & PRESCALE_MASK);
        first_bit = 1'b0;
        rbit = 1'b0;
        next_serial_prescaler   = serial_prescaler;
        next_serial_control_a   = serial_control_a;
        next_serial_irq_control = serial_irq_control;
        next_tx_holding_reg     = tx_holding_reg;
        next_rx_holding_reg     = rx_holding_reg;
        next_tx_empty_flag      = tx_empty_flag;
        next_rx_full_flag       = rx_full_flag;
        next_tx_done_flag       = tx_done_flag;
        next_overrun_flag       = overrun_flag;
        next_shift_out          = shift_out;
        next_shift_in           = shift_in;
        next_bit_cnt            = bit_cnt;
        next_div_cnt            = tick ? ((hp == 8'h00) ? 8'h01 : hp) - 8'h01 : div_cnt - 8'h01;
        next_state              = state;
        next_sclk               = sclk;
        next_txd                = txd;
        next_ssel               = ssel;
        next_rdata              = 8'h00;

        if (sfr_req.rd) begin
            if (hit(sfr_req, OFS_PRESCALER))   next_rdata = serial_prescaler & PRESCALE_MASK;
            if (hit(sfr_req, OFS_STATUS))      next_rdata = st;
            if (hit(sfr_req, OFS_RX_HOLD))     next_rdata = rx_holding_reg;
            if (hit(sfr_req, OFS_CONTROL_A))   next_rdata = serial_control_a;
            if (hit(sfr_req, OFS_IRQ_CONTROL)) next_rdata = serial_irq_control;
            if (hit(sfr_req, OFS_STATUS)) begin
                next_tx_done_flag = 1'b0;
                next_overrun_flag = 1'b0;
            end
            if (hit(sfr_req, OFS_RX_HOLD))
                next_rx_full_flag = 1'b0;
        end
        if (sfr_req.wr) begin
            if (hit(sfr_req, OFS_PRESCALER))   next_serial_prescaler = sfr_req.wdata & PRESCALE_MASK;
            if (hit(sfr_req, OFS_CONTROL_A))   next_serial_control_a = sfr_req.wdata & 8'h7E;
            if (hit(sfr_req, OFS_IRQ_CONTROL)) next_serial_irq_control = sfr_req.wdata & 8'h0F;
            if (hit(sfr_req, OFS_TX_HOLD)) begin
                next_tx_holding_reg = sfr_req.wdata;
                next_tx_empty_flag  = 1'b0;
            end
        end

        case (state)
            SPIM_IDLE: begin
                next_sclk = clock_idle_polarity;
                if (!auto_sel)
                    next_ssel = 1'b1;
                if (serial_if_on && tx_allow && !tx_empty_flag && tick) begin
                    next_shift_out     = tx_holding_reg;
                    // A same-cycle write refills the holding register, so its byte is kept
                    next_tx_empty_flag = !(sfr_req.wr && hit(sfr_req, OFS_TX_HOLD));
                    next_bit_cnt       = 3'h0;
                    next_ssel          = !auto_sel;
                    next_state         = SPIM_SETUP;
                end
            end
            // Select has had one tick to settle before the first edge
            SPIM_SETUP: if (tick) begin
                first_bit = 1'b1;
                next_state = SPIM_LEAD;
            end
            // Drive edge of every later bit; clock is back at idle here
            SPIM_LEAD: if (tick) begin
                first_bit = 1'b1;
            end
            SPIM_TRAIL: if (tick) begin
                // Sampling edge: falling for polarity 0, rising for 1
                next_sclk = !sclk;
                rbit = serial_rx_line;
                if (rx_allow)
                    next_shift_in = lsb_first_order ? {rbit, shift_in[7:1]} : {shift_in[6:0], rbit};
                if (bit_cnt == LAST_BIT) begin
                    next_state        = SPIM_IDLE;
                    next_tx_done_flag = 1'b1;
                    next_ssel         = 1'b1;
                    if (rx_allow) begin
                        next_rx_holding_reg = lsb_first_order ? {rbit, shift_in[7:1]} : {shift_in[6:0], rbit};
                        next_rx_full_flag   = 1'b1;
                        if (rx_full_flag && !(sfr_req.rd && hit(sfr_req, OFS_RX_HOLD)))
                            next_overrun_flag = 1'b1;
                    end
                end else begin
                    // Next bit waits a full tick so sample and drive never share an edge
                    next_bit_cnt = bit_cnt + 3'h1;
                    next_state   = SPIM_LEAD;
                end
            end
            default: next_state = SPIM_IDLE;
        endcase
        // Bit leaves on the leading edge of its period
        if (first_bit) begin
            next_sclk = !sclk;
            next_txd  = lsb_first_order ? shift_out[0] : shift_out[7];
            next_shift_out = lsb_first_order ? {1'b0, shift_out[7:1]} : {shift_out[6:0], 1'b0};
            next_state = SPIM_TRAIL;
        end
        // Clearing transmitter or interface aborts immediately, clock parks
        if (!tx_allow || !serial_if_on) begin
            next_state = SPIM_IDLE;
            next_sclk  = clock_idle_polarity;
            next_ssel  = 1'b1;
        end
        next_irq = |({next_tx_done_flag, next_overrun_flag, next_tx_empty_flag, next_rx_full_flag}
                     & serial_irq_control[3:0]);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            serial_prescaler   <= RST_PRESCALER;
            serial_control_a   <= RST_CONTROL_A;
            serial_irq_control <= RST_IRQ_CONTROL;
            tx_holding_reg     <= 8'h00;
            rx_holding_reg     <= 8'h00;
            tx_empty_flag      <= 1'b1;
            rx_full_flag       <= 1'b0;
            tx_done_flag       <= 1'b0;
            overrun_flag       <= 1'b0;
            shift_out          <= 8'h00;
            shift_in           <= 8'h00;
            bit_cnt            <= 3'h0;
            div_cnt            <= 8'h00;
            state              <= SPIM_IDLE;
            sclk               <= 1'b0;
            txd                <= 1'b0;
            ssel               <= 1'b1;
            rdata              <= 8'h00;
            irq                <= 1'b0;
        end else begin
            serial_prescaler   <= next_serial_prescaler;
            serial_control_a   <= next_serial_control_a;
            serial_irq_control <= next_serial_irq_control;
            tx_holding_reg     <= next_tx_holding_reg;
            rx_holding_reg     <= next_rx_holding_reg;
            tx_empty_flag      <= next_tx_empty_flag;
            rx_full_flag       <= next_rx_full_flag;
            tx_done_flag       <= next_tx_done_flag;
            overrun_flag       <= next_overrun_flag;
            shift_out          <= next_shift_out;
            shift_in           <= next_shift_in;
            bit_cnt            <= next_bit_cnt;
            div_cnt            <= next_div_cnt;
            state              <= next_state;
            sclk               <= next_sclk;
            txd                <= next_txd;
            ssel               <= next_ssel;
            rdata              <= next_rdata;
            irq                <= next_irq;
        end
    end

    assign sfr_rdata        = rdata;
    assign spi_irq          = irq;
    assign serial_clock_out = sclk;
    assign serial_tx_line   = txd;
    assign slave_select_out = ssel;

    sequence s_tx_off;
        !serial_control_a[POS_TX_ALLOW];
    endsequence

    AST_TX_OFF_PARKS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_tx_off ##1 s_tx_off |-> serial_clock_out == clock_idle_polarity)
        else $error("Clock not parked while transmitter off");
    AST_IF_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !serial_if_on |=> state == SPIM_IDLE)
        else $error("Transfer running while interface off");
    AST_SEL_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!auto_sel && !busy) |=> slave_select_out)
        else $error("Select low with auto select off");
    AST_SEL_LOW_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busy && $past(auto_sel) && auto_sel && $past(busy)) |-> !slave_select_out)
        else $error("Select high during auto byte");
    AST_STATUS_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (sfr_req.rd && sfr_req.addr == OFS_STATUS && state != SPIM_TRAIL) |=> !tx_done_flag && !overrun_flag)
        else $error("Status read did not clear flags");
    AST_TX_EMPTY_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (sfr_req.wr && sfr_req.addr == OFS_TX_HOLD) |=> !tx_empty_flag)
        else $error("Tx empty not cleared by write");
    AST_RX_OFF_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !rx_allow |=> $stable(rx_holding_reg))
        else $error("Receive register changed with receiver off");
    AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (serial_irq_control[3:0] == 4'h0 && $past(serial_irq_control[3:0]) == 4'h0) |-> !spi_irq)
        else $error("Interrupt with all enables off");

    // Phases of one byte, for the edge-by-edge checks below
    sequence s_byte_start;
        state == SPIM_IDLE && tick && serial_if_on && tx_allow && !tx_empty_flag && auto_sel;
    endsequence

    sequence s_load;
        state == SPIM_IDLE && tick && serial_if_on && tx_allow && !tx_empty_flag
            && !(sfr_req.wr && sfr_req.addr == OFS_TX_HOLD);
    endsequence

    sequence s_drive_edge;
        tick && serial_if_on && tx_allow && (state == SPIM_SETUP || state == SPIM_LEAD);
    endsequence

    sequence s_sample_edge;
        tick && state == SPIM_TRAIL;
    endsequence

    sequence s_byte_end;
        tick && serial_if_on && tx_allow && state == SPIM_TRAIL && bit_cnt == LAST_BIT;
    endsequence

    sequence s_rx_land;
        tick && serial_if_on && tx_allow && rx_allow && state == SPIM_TRAIL && bit_cnt == LAST_BIT;
    endsequence

    AST_SEL_FALLS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_byte_start |=> !slave_select_out && state == SPIM_SETUP)
        else $error("Select did not fall before first bit");
    AST_SEL_RISES: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_byte_end |=> slave_select_out && !busy)
        else $error("Select did not rise after eighth bit");
    AST_TX_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_load |=> tx_empty_flag && busy)
        else $error("Tx empty not set on load");
    AST_DRIVE_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_drive_edge |=> $changed(serial_clock_out) && serial_clock_out != clock_idle_polarity)
        else $error("Drive edge missing");
    AST_SAMPLE_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_sample_edge |=> serial_clock_out == clock_idle_polarity)
        else $error("Clock not back at idle level after sample");
    AST_RX_LANDS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_rx_land |=> rx_full_flag && tx_done_flag)
        else $error("Received byte did not raise rx full");
    AST_IRQ_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_b)
        spi_irq == |({tx_done_flag, overrun_flag, tx_empty_flag, rx_full_flag} & $past(serial_irq_control[3:0])))
        else $error("Interrupt does not follow enabled flags");
endmodule
`default_nettype wire

// File: verif/spim_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spim_slave_model (
    input  wire logic       serial_clock_out,
    input  wire logic       slave_select_out,
    input  wire logic       serial_tx_line,
    input  wire logic       polarity,
    input  wire logic       lsb_first,
    input  wire logic [7:0] reply,
    output logic            serial_rx_line,
    output logic [7:0]      heard,
    output int unsigned     n_heard
);
    logic [2:0] idx = 3'h0;
    logic [2:0] pos;
    logic       armed = 1'b0;
    initial serial_rx_line = 1'b0;
    initial heard = 8'h00;
    initial n_heard = 0;
    // Released line flips so a stale bit never passes for data
    always @(posedge slave_select_out) serial_rx_line = ~serial_rx_line;
    always @(negedge slave_select_out) idx = 3'h0;
    // Select may rise in the same step as the last sample edge, so the drive edge arms the sample
    always @(serial_clock_out) begin
        pos = lsb_first ? idx : 3'h7 - idx;
        if (slave_select_out === 1'b0 && serial_clock_out !== polarity) begin
            serial_rx_line = reply[pos];
            armed = 1'b1;
        end else if (armed) begin
            heard[pos] = serial_tx_line;
            n_heard = n_heard + ((idx == 3'h7) ? 1 : 0);
            idx = idx + 3'h1;
            armed = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verif/spi_master_dynamic_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_dynamic_control_tb;
    import spim_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst_b = 1'b0;
    spim_sfr_req_t sfr_req = '0;
    logic [7:0]    sfr_rdata, heard, b, r;
    logic          spi_irq, serial_clock_out, serial_tx_line, slave_select_out, serial_rx_line;
    logic          pol = 1'b0, lsb = 1'b0, rd_pend = 1'b0;
    logic [7:0]    reply = 8'h00;
    int unsigned   n_heard, seen = 0, start;
    int            err_total = 0, n_compared = 0, seed = 40, cnt, i, k;
    logic [7:0]    exp_q[$], wire_q[$];
    string         name_q[$];
    logic [7:0]    pres[4] = '{8'h04, 8'h0C, 8'h24, 8'h84};
    logic [7:0]    offv[2] = '{8'h3E, 8'h6E};
    always #2.5 sys_clk = ~sys_clk;
    spim_master uut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .spi_irq(spi_irq), .serial_clock_out(serial_clock_out), .serial_tx_line(serial_tx_line),
        .slave_select_out(slave_select_out), .serial_rx_line(serial_rx_line));
    spim_slave_model slv (.serial_clock_out(serial_clock_out), .slave_select_out(slave_select_out),
        .serial_tx_line(serial_tx_line), .polarity(pol), .lsb_first(lsb), .reply(reply),
        .serial_rx_line(serial_rx_line), .heard(heard), .n_heard(n_heard));
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) sfr_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk) sfr_req <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(posedge sys_clk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk) begin
            sfr_req <= '0;
            rd_pend <= 1'b1;
        end
        @(posedge sys_clk) rd_pend <= 1'b0;
    endtask
    // Read data stands one cycle, so it is taken at exactly that edge
    always @(posedge sys_clk) begin
        if (rd_pend === 1'b1) chk(name_q.pop_front(), exp_q.pop_front(), sfr_rdata);
        if (n_heard != seen) begin
            seen = n_heard;
            chk("wire byte", wire_q.pop_front(), heard);
        end
    end
    task xfer(input logic [7:0] d, input logic [7:0] rr, input int cyc);
        reply = rr;
        wire_q.push_back(d);
        start = n_heard;
        wr(OFS_TX_HOLD, d);
        cnt = 0;
        for (k = 0; k < 20000 && n_heard == start; k++) begin
            @(posedge sys_clk);
            cnt += (slave_select_out === 1'b0);
        end
        if (k >= 20000) begin
            chk("transfer timeout", 1, 0);
            conclude();
        end
        repeat (4) @(posedge sys_clk);
        if (cyc != 0) chk("select low cycles", 16'(cyc), 16'(cnt));
    endtask
    task hold_idle(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge sys_clk);
            cnt += (slave_select_out !== 1'b1 || serial_clock_out !== pol);
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_PRESCALER, RST_PRESCALER, "prescaler");
        rd(OFS_CONTROL_A, RST_CONTROL_A, "control_a");
        rd(OFS_IRQ_CONTROL, RST_IRQ_CONTROL, "irq_control");
        rd(OFS_STATUS, 8'h02, "status");
        rd(8'hD0, 8'h00, "unmapped");
        wr(OFS_CONTROL_A, 8'hFF);
        rd(OFS_CONTROL_A, 8'h7E, "control_a");
        wr(OFS_IRQ_CONTROL, 8'hFF);
        rd(OFS_IRQ_CONTROL, 8'h0F, "irq_control");
        wr(OFS_PRESCALER, 8'hFF);
        rd(OFS_PRESCALER, 8'hFC, "prescaler");
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            pol = i[0];
            lsb = i[1];
            wr(OFS_PRESCALER, pres[i]);
            wr(OFS_IRQ_CONTROL, 8'h08);
            wr(OFS_CONTROL_A, {5'h0F, lsb, pol, 1'b0});
            b = 8'($random(seed));
            r = 8'($random(seed));
            xfer(b, r, 8 * (pres[i] & 8'hFC));
            chk("irq", 1, spi_irq);
            rd(OFS_STATUS, 8'h0B, "status");
            @(posedge sys_clk);
            chk("irq", 0, spi_irq);
            rd(OFS_RX_HOLD, r, "rx hold");
            rd(OFS_STATUS, 8'h02, "status");
            chk("idle clock", pol, serial_clock_out);
            $display("test mode %0d done", i);
        end
        wr(OFS_PRESCALER, 8'h04);
        wr(OFS_IRQ_CONTROL, 8'h00);
        xfer(b, 8'h5A, 0);
        xfer(b, 8'hA5, 0);
        chk("irq masked", 0, spi_irq);
        wr(OFS_IRQ_CONTROL, 8'h04);
        repeat (2) @(posedge sys_clk);
        chk("irq overrun", 1, spi_irq);
        rd(OFS_STATUS, 8'h0F, "status");
        rd(OFS_RX_HOLD, 8'hA5, "rx hold");
        $display("test overrun done");
        wr(OFS_CONTROL_A, 8'h5E);
        xfer(b, 8'h3C, 0);
        rd(OFS_STATUS, 8'h0A, "status");
        rd(OFS_RX_HOLD, 8'hA5, "rx hold");
        $display("test receiver off done");
        wr(OFS_CONTROL_A, 8'h76);
        wr(OFS_TX_HOLD, b);
        hold_idle(32);
        cnt = 0;
        repeat (80) begin
            @(posedge sys_clk);
            cnt += (slave_select_out !== 1'b1);
        end
        chk("select held", 0, 16'(cnt));
        rd(OFS_STATUS, 8'h0B, "status");
        $display("test select off done");
        for (i = 0; i < 2; i++) begin
            wr(OFS_CONTROL_A, offv[i]);
            wr(OFS_TX_HOLD, b);
            hold_idle(100);
            chk("lines idle", 0, 16'(cnt));
        end
        $display("test disabled done");
        conclude();
    end
endmodule
`default_nettype wire
